// file: sim/radio_env.sv
// low-frequency oscillators and signal detector facing the wake-up timer
`timescale 1ns/1ps
module radio_env
(
    input  wire logic clk,
    input  wire logic receiver_on,
    input  wire logic carrier,
    output logic      rc_osc_clk,
    output logic      crystal_osc_clk,
    output logic      preamble_valid,
    output logic      sync_word_detected
);
    initial
    begin
        rc_osc_clk = 1'b0;
        crystal_osc_clk = 1'b0;
        preamble_valid = 1'b0;
        sync_word_detected = 1'b0;
    end
    // both sources run far faster than real so a period fits a short run: rc tick 8 clk, crystal 16 clk
    always #20 rc_osc_clk = ~rc_osc_clk;
    always #40 crystal_osc_clk = ~crystal_osc_clk;
    // the detector only reports while the receiver listens; sync follows the preamble
    always @(posedge clk)
    begin
        preamble_valid <= receiver_on && carrier;
        sync_word_detected <= preamble_valid && receiver_on;
    end
endmodule : radio_env

// file: sim/tb_top.sv
// self-checking bench for the wake-up timer
`timescale 1ns/1ps
module tb_top;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic       carrier = 1'b0;
    logic [7:0] reg_rdata;
    logic       rc_osc_clk, crystal_osc_clk, preamble_valid, sync_word_detected, interrupt_request_n;
    logic       timer_expiry_pin, crystal_osc_enable, receiver_on, sleep_state;
    logic       general_pin_zero_crystal, host_clock_lf_source;
    int         n_mismatch = 0;
    int         num_checks = 0;
    always #2.5 clk = ~clk;
    wakeup_timer dut
    (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .rc_osc_clk(rc_osc_clk), .crystal_osc_clk(crystal_osc_clk),
        .preamble_valid(preamble_valid), .sync_word_detected(sync_word_detected),
        .interrupt_request_n(interrupt_request_n), .timer_expiry_pin(timer_expiry_pin),
        .crystal_osc_enable(crystal_osc_enable), .receiver_on(receiver_on), .sleep_state(sleep_state),
        .general_pin_zero_crystal(general_pin_zero_crystal), .host_clock_lf_source(host_clock_lf_source)
    );
    radio_env env
    (
        .clk(clk), .receiver_on(receiver_on), .carrier(carrier), .rc_osc_clk(rc_osc_clk),
        .crystal_osc_clk(crystal_osc_clk), .preamble_valid(preamble_valid), .sync_word_detected(sync_word_detected)
    );
    // ----------------------------------------
    // shared tasks: every bus task syncs to an edge first and returns just after one
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic span(input string what, input int n, input int lo, input int hi);
        check(what, {15'h0000, n >= lo && n <= hi}, 16'h0001);
    endtask : span
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check(what, {8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd_chk
    task automatic pause(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : pause
    // bounded wait; n is the number of clock edges it took
    task automatic wait_for(ref logic s, input logic lvl, output int n);
        n = 0;
        while (s !== lvl && n < 3000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 3000)
            n_mismatch++;
    endtask : wait_for
    // ----------------------------------------
    // scenarios; one rc tick is 8 clk, one crystal tick 16 clk
    // ----------------------------------------
    task automatic t_regs;
        rd_chk("exp_cfg", 8'h14, 8'h00);
        rd_chk("mant_hi", 8'h15, 8'h00);
        rd_chk("mant_lo", 8'h16, 8'h00);
        rd_chk("window", 8'h19, 8'h00);
        wr(8'h14, 8'hFF);
        wr(8'h15, 8'hA5);
        wr(8'h16, 8'h5A);
        wr(8'h19, 8'hC3);
        wr(8'h17, 8'hFF);
        rd_chk("exp_cfg", 8'h14, 8'h3F);
        rd_chk("mant_hi", 8'h15, 8'hA5);
        rd_chk("mant_lo", 8'h16, 8'h5A);
        rd_chk("window", 8'h19, 8'hC3);
        rd_chk("count_hi", 8'h17, 8'h00);
        rd_chk("count_lo", 8'h18, 8'h00);
        rd_chk("unmapped", 8'h30, 8'h00);
        wr(8'h14, 8'h00);
        wr(8'h15, 8'h00);
        $display("test registers done");
    endtask : t_regs
    task automatic t_period;
        int n;
        int x;
        wr(8'h16, 8'h03);
        wr(8'h1A, 8'h22);
        pause(200);
        check("no_enable", {15'h0000, interrupt_request_n}, 16'h0001);
        for (int i = 0; i < 3; i++)
        begin
            x = (3 - i) * 32 * (1 << i);
            wr(8'h14, 8'(i * 4));
            wr(8'h16, 8'(3 - i));
            wr(8'h1A, 8'h23);
            wait_for(interrupt_request_n, 1'b0, n);
            span("period", n, x - 10, x + 10);
            rd_chk("status", 8'h1B, 8'h03);
            check("awake", {14'h0000, crystal_osc_enable, sleep_state}, 16'h0002);
            wr(8'h1C, 8'h01);
            rd_chk("status_clr", 8'h1B, 8'h02);
            check("irq_release", {15'h0000, interrupt_request_n}, 16'h0001);
            wr(8'h1A, 8'h00);
        end
        $display("test period done");
    endtask : t_period
    task automatic t_crystal;
        int n;
        wr(8'h14, 8'h00);
        wr(8'h16, 8'h03);
        wr(8'h1A, 8'h27);
        pause(96);
        check("xtal_route", {14'h0000, general_pin_zero_crystal, host_clock_lf_source}, 16'h0003);
        rd_chk("count_hi", 8'h17, 8'h00);
        rd_chk("count_lo", 8'h18, 8'h01);
        wait_for(interrupt_request_n, 1'b0, n);
        span("xtal_period", n + 100, 172, 202);
        wr(8'h1C, 8'h01);
        wr(8'h1A, 8'h00);
        rd_chk("status_xtal", 8'h1B, 8'h02);
        check("rc_route", {14'h0000, general_pin_zero_crystal, host_clock_lf_source}, 16'h0000);
        $display("test crystal done");
    endtask : t_crystal
    task automatic t_pin;
        int n;
        wr(8'h16, 8'h02);
        wr(8'h1A, 8'h31);
        wait_for(timer_expiry_pin, 1'b1, n);
        span("pin_first", n, 54, 74);
        wait_for(timer_expiry_pin, 1'b0, n);
        wait_for(timer_expiry_pin, 1'b1, n);
        span("pin_repeat", n + 1, 58, 70);
        check("pin_state", {14'h0000, interrupt_request_n, sleep_state}, 16'h0003);
        wr(8'h1A, 8'h00);
        wr(8'h1C, 8'h01);
        $display("test pin done");
    endtask : t_pin
    task automatic t_ldc;
        int n;
        wr(8'h19, 8'h02);
        wr(8'h16, 8'h04);
        wr(8'h1A, 8'h29);
        wait_for(receiver_on, 1'b1, n);
        wait_for(receiver_on, 1'b0, n);
        span("window", n, 54, 74);
        pause(3);
        check("ldc_sleep", {15'h0000, sleep_state}, 16'h0001);
        wait_for(receiver_on, 1'b1, n);
        pause(40);
        carrier = 1'b1;
        wait_for(receiver_on, 1'b0, n);
        span("window_ext", n + 40, 96, 125);
        carrier = 1'b0;
        wr(8'h1A, 8'h00);
        $display("test duty cycle done");
    endtask : t_ldc
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_period();
        t_crystal();
        t_pin();
        t_ldc();
        close_out();
    end
    // the whole run needs about 1400 clocks; twenty times that means a hang
    initial
    begin
        #150us;
        n_mismatch++;
        close_out();
    end
endmodule : tb_top

// file: sim/wakeup_timer_chk.sv
// port assertions for the wake-up timer
`timescale 1ns/1ps
module wakeup_timer_chk
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       rc_osc_clk,
    input wire logic       crystal_osc_clk,
    input wire logic       preamble_valid,
    input wire logic       sync_word_detected,
    input wire logic       interrupt_request_n,
    input wire logic       timer_expiry_pin,
    input wire logic       crystal_osc_enable,
    input wire logic       receiver_on,
    input wire logic       sleep_state,
    input wire logic       general_pin_zero_crystal,
    input wire logic       host_clock_lf_source
);
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // shadow of the control register
    // ----------------------------------------
    always_comb
    begin
        ctl_nxt = ctl_r;
        if (reg_write && reg_addr == wakeup_timer_pkg::control_addr)
            ctl_nxt = reg_wdata;
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ctl_r <= 8'h00;
        else
            ctl_r <= ctl_nxt;
    end
    sequence woken_s;
        crystal_osc_enable && !sleep_state;
    endsequence
    irq_needs_en_a: assert property ($fell(interrupt_request_n) |-> $past(ctl_r[1]))
        else $error("irq fell without enable");
    irq_wakes_a: assert property ($fell(interrupt_request_n) |-> ##[0:2] woken_s)
        else $error("irq without wake");
    irq_holds_a: assert property (!interrupt_request_n && !reg_write && !$past(reg_write) |=> !interrupt_request_n)
        else $error("irq dropped by itself");
    pin_pulse_a: assert property (timer_expiry_pin |=> !timer_expiry_pin)
        else $error("expiry pin longer than one cycle");
    pin_route_a: assert property ($rose(timer_expiry_pin) |-> $past(ctl_r[4]))
        else $error("expiry pin without route");
    xtal_pin_a: assert property ($changed(ctl_r[2]) |-> ##[0:2] (general_pin_zero_crystal == ctl_r[2]))
        else $error("pin zero not following select");
    lf_agree_a: assert property (general_pin_zero_crystal == host_clock_lf_source && host_clock_lf_source == $past(ctl_r[2]))
        else $error("clock sources disagree");
    rx_needs_ldc_a: assert property ($rose(receiver_on) |-> $past(ctl_r[3]))
        else $error("receiver on without duty mode");
    rx_end_sleep_a: assert property ($fell(receiver_on) && ctl_r[5] |-> ##[0:2] sleep_state)
        else $error("no sleep after window");
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
endmodule : wakeup_timer_chk
bind wakeup_timer wakeup_timer_chk chk
(
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .rc_osc_clk(rc_osc_clk), .crystal_osc_clk(crystal_osc_clk),
    .preamble_valid(preamble_valid), .sync_word_detected(sync_word_detected),
    .interrupt_request_n(interrupt_request_n), .timer_expiry_pin(timer_expiry_pin),
    .crystal_osc_enable(crystal_osc_enable), .receiver_on(receiver_on), .sleep_state(sleep_state),
    .general_pin_zero_crystal(general_pin_zero_crystal), .host_clock_lf_source(host_clock_lf_source)
);

// file: verilog/wakeup_timer.sv
// wake-up timer with low-duty-cycle receive window scheduling
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module wakeup_timer
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       rc_osc_clk,
    input  wire logic       crystal_osc_clk,
    input  wire logic       preamble_valid,
    input  wire logic       sync_word_detected,
    output logic            interrupt_request_n,
    output logic            timer_expiry_pin,
    output logic            crystal_osc_enable,
    output logic            receiver_on,
    output logic            sleep_state,
    output logic            general_pin_zero_crystal,
    output logic            host_clock_lf_source
);
    // ------------------------------------------------------------
    // state machine and registers
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        st_awake  = 4'h1,
        st_sleep  = 4'h2,
        st_listen = 4'h4,
        st_extend = 4'h8
    } mode_t;

    mode_t       mode_r, mode_nxt;
    logic [7:0]  exp_cfg_r, exp_cfg_nxt;
    logic [7:0]  mant_hi_r, mant_hi_nxt;
    logic [7:0]  mant_lo_r, mant_lo_nxt;
    logic [7:0]  window_r, window_nxt;
    logic [7:0]  ctl_r, ctl_nxt;
    logic        expired_r, expired_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic [15:0] count_r, count_nxt;
    logic [1:0]  quarter_r, quarter_nxt;
    logic [15:0] prescale_r, prescale_nxt;
    logic [23:0] window_cnt_r, window_cnt_nxt;
    logic [2:0]  rc_sync_r, rc_sync_nxt;
    logic [2:0]  xt_sync_r, xt_sync_nxt;
    logic [2:0]  pre_sync_r, pre_sync_nxt;
    logic [2:0]  syn_sync_r, syn_sync_nxt;
    logic        lf_level_r, lf_level_nxt;
    logic        pre_level_r, pre_level_nxt;
    logic        syn_level_r, syn_level_nxt;
    logic        irq_n_r, irq_n_nxt;
    logic        pin_r, pin_nxt;
    logic        xton_r, xton_nxt;
    logic        rxon_r, rxon_nxt;
    logic        sleep_r, sleep_nxt;
    logic        gp0_r, gp0_nxt;
    logic        hclk_r, hclk_nxt;

    // filtered level: changes once second and third stage agree
    function automatic logic filt(input logic [2:0] s, input logic prev);
        filt = (s[2] == s[1]) ? s[1] : prev;
    endfunction : filt

    // scaled length: 2^exp - 1 prescale limit for one unit
    function automatic logic [15:0] unit_limit(input logic [3:0] e);
        unit_limit = 16'((32'h1 << e) - 32'h1);
    endfunction : unit_limit

    logic [3:0]  exponent;
    logic [15:0] mantissa;
    logic        lf_tick;
    logic        unit_tick;
    logic        expire;
    logic        timer_run;

    always_comb
    begin
        exponent = exp_cfg_r[wakeup_timer_pkg::exponent_lsb +: 4];
        mantissa = {mant_hi_r, mant_lo_r};
    end

    always_comb
    begin
        rc_sync_nxt  = {rc_sync_r[1:0], rc_osc_clk};
        xt_sync_nxt  = {xt_sync_r[1:0], crystal_osc_clk};
        pre_sync_nxt = {pre_sync_r[1:0], preamble_valid};
        syn_sync_nxt = {syn_sync_r[1:0], sync_word_detected};
        pre_level_nxt = filt(pre_sync_r, pre_level_r);
        syn_level_nxt = filt(syn_sync_r, syn_level_r);
        lf_level_nxt = ctl_r[wakeup_timer_pkg::ctl_crystal_sel] ? filt(xt_sync_r, lf_level_r)
                                                                : filt(rc_sync_r, lf_level_r);
        lf_tick = lf_level_nxt & ~lf_level_r;
        timer_run = ctl_r[wakeup_timer_pkg::ctl_timer_enable] & (mode_r != st_awake);
    end

    // ------------------------------------------------------------
    // timer counting
    // ------------------------------------------------------------
    always_comb
    begin
        quarter_nxt  = quarter_r;
        prescale_nxt = prescale_r;
        count_nxt    = count_r;
        unit_tick    = 1'b0;
        expire       = 1'b0;
        if (!timer_run)
        begin
            quarter_nxt  = 2'h0;
            prescale_nxt = 16'h0000;
            count_nxt    = 16'h0000;
        end
        else if (lf_tick)
        begin
            // four clocks per unit, scaled by 2^exp
            quarter_nxt = 2'(quarter_r + 2'h1);
            if (quarter_r == 2'(wakeup_timer_pkg::ticks_per_unit - 3'h1))
            begin
                if (prescale_r >= unit_limit(exponent))
                begin
                    prescale_nxt = 16'h0000;
                    unit_tick    = 1'b1;
                end
                else
                begin
                    prescale_nxt = 16'(prescale_r + 16'h0001);
                end
            end
        end
        if (timer_run && unit_tick)
        begin
            if (count_r + 17'h00001 >= {1'b0, mantissa} && mantissa != 16'h0000)
            begin
                expire    = 1'b1;
                count_nxt = 16'h0000;
            end
            else
            begin
                count_nxt = 16'(count_r + 16'h0001);
            end
        end
    end

    // ------------------------------------------------------------
    // mode control, receive window and outputs
    // ------------------------------------------------------------
    always_comb
    begin
        mode_nxt       = mode_r;
        window_cnt_nxt = window_cnt_r;
        xton_nxt       = xton_r;
        pin_nxt        = 1'b0;
        irq_n_nxt      = ~(expired_r & ctl_r[wakeup_timer_pkg::ctl_irq_enable]);
        gp0_nxt        = ctl_r[wakeup_timer_pkg::ctl_crystal_sel];
        hclk_nxt       = ctl_r[wakeup_timer_pkg::ctl_crystal_sel];
        unique case (mode_r)
            st_awake:
            begin
                if (ctl_r[wakeup_timer_pkg::ctl_sleep_cmd])
                begin
                    mode_nxt = st_sleep;
                    xton_nxt = 1'b0;
                end
            end
            st_sleep:
            begin
                if (expire)
                begin
                    pin_nxt = ctl_r[wakeup_timer_pkg::ctl_pin_route];
                    if (ctl_r[wakeup_timer_pkg::ctl_irq_enable])
                    begin
                        mode_nxt = st_awake;
                        xton_nxt = 1'b1;
                    end
                    else if (ctl_r[wakeup_timer_pkg::ctl_ldc_enable])
                    begin
                        mode_nxt       = st_listen;
                        window_cnt_nxt = 24'h000000;
                    end
                end
            end
            st_listen, st_extend:
            begin
                if (expire)
                begin
                    pin_nxt = ctl_r[wakeup_timer_pkg::ctl_pin_route];
                end
                if (mode_r == st_listen && pre_level_r && syn_level_r)
                begin
                    mode_nxt       = st_extend;
                    window_cnt_nxt = 24'h000000;
                end
                else if (unit_tick)
                begin
                    // window length in the same scaled units
                    if (window_cnt_r + 24'h000001 >= {16'h0000, window_r})
                    begin
                        mode_nxt = st_sleep;
                    end
                    window_cnt_nxt = 24'(window_cnt_r + 24'h000001);
                end
                if (!ctl_r[wakeup_timer_pkg::ctl_sleep_cmd])
                begin
                    mode_nxt = st_awake;
                end
            end
        endcase
        if (mode_r == st_sleep && !ctl_r[wakeup_timer_pkg::ctl_sleep_cmd])
        begin
            mode_nxt = st_awake;
            xton_nxt = 1'b1;
        end
        rxon_nxt  = (mode_nxt == st_listen) || (mode_nxt == st_extend);
        sleep_nxt = (mode_nxt == st_sleep);
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_comb
    begin
        exp_cfg_nxt = exp_cfg_r;
        mant_hi_nxt = mant_hi_r;
        mant_lo_nxt = mant_lo_r;
        window_nxt  = window_r;
        ctl_nxt     = ctl_r;
        expired_nxt = expired_r;
        rdata_nxt   = 8'h00;
        if (reg_write)
        begin
            unique case (reg_addr)
                wakeup_timer_pkg::period_exponent_cfg_addr:  exp_cfg_nxt = {2'h0, reg_wdata[5:0]};
                wakeup_timer_pkg::period_mantissa_high_addr: mant_hi_nxt = reg_wdata;
                wakeup_timer_pkg::period_mantissa_low_addr:  mant_lo_nxt = reg_wdata;
                wakeup_timer_pkg::receive_window_addr:       window_nxt  = reg_wdata;
                wakeup_timer_pkg::control_addr:              ctl_nxt     = {2'h0, reg_wdata[5:0]};
                wakeup_timer_pkg::status_clear_addr:         expired_nxt = expired_r & ~reg_wdata[0];
                default: ;
            endcase
        end
        // set wins over clear
        if (expire)
        begin
            expired_nxt = 1'b1;
        end
        // an interrupt wake drops the sleep command, else the block would fall straight back asleep
        if (expire && mode_r == st_sleep && ctl_r[wakeup_timer_pkg::ctl_irq_enable])
        begin
            ctl_nxt[wakeup_timer_pkg::ctl_sleep_cmd] = 1'b0;
        end
        if (reg_read)
        begin
            unique case (reg_addr)
                wakeup_timer_pkg::period_exponent_cfg_addr:  rdata_nxt = exp_cfg_r;
                wakeup_timer_pkg::period_mantissa_high_addr: rdata_nxt = mant_hi_r;
                wakeup_timer_pkg::period_mantissa_low_addr:  rdata_nxt = mant_lo_r;
                wakeup_timer_pkg::count_high_addr:           rdata_nxt = count_r[15:8];
                wakeup_timer_pkg::count_low_addr:            rdata_nxt = count_r[7:0];
                wakeup_timer_pkg::receive_window_addr:       rdata_nxt = window_r;
                wakeup_timer_pkg::control_addr:              rdata_nxt = ctl_r;
                wakeup_timer_pkg::status_addr:               rdata_nxt = {3'h0, mode_r, expired_r};
                default:                                     rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_r       <= st_awake;
            exp_cfg_r    <= wakeup_timer_pkg::period_exponent_cfg_rst;
            mant_hi_r    <= wakeup_timer_pkg::mantissa_rst;
            mant_lo_r    <= wakeup_timer_pkg::mantissa_rst;
            window_r     <= wakeup_timer_pkg::receive_window_rst;
            ctl_r        <= wakeup_timer_pkg::control_rst;
            expired_r    <= 1'b0;
            rdata_r      <= 8'h00;
            count_r      <= 16'h0000;
            quarter_r    <= 2'h0;
            prescale_r   <= 16'h0000;
            window_cnt_r <= 24'h000000;
            rc_sync_r    <= 3'h0;
            xt_sync_r    <= 3'h0;
            pre_sync_r   <= 3'h0;
            syn_sync_r   <= 3'h0;
            lf_level_r   <= 1'b0;
            pre_level_r  <= 1'b0;
            syn_level_r  <= 1'b0;
            irq_n_r      <= 1'b1;
            pin_r        <= 1'b0;
            xton_r       <= 1'b1;
            rxon_r       <= 1'b0;
            sleep_r      <= 1'b0;
            gp0_r        <= 1'b0;
            hclk_r       <= 1'b0;
        end
        else
        begin
            mode_r       <= mode_nxt;
            exp_cfg_r    <= exp_cfg_nxt;
            mant_hi_r    <= mant_hi_nxt;
            mant_lo_r    <= mant_lo_nxt;
            window_r     <= window_nxt;
            ctl_r        <= ctl_nxt;
            expired_r    <= expired_nxt;
            rdata_r      <= rdata_nxt;
            count_r      <= count_nxt;
            quarter_r    <= quarter_nxt;
            prescale_r   <= prescale_nxt;
            window_cnt_r <= window_cnt_nxt;
            rc_sync_r    <= rc_sync_nxt;
            xt_sync_r    <= xt_sync_nxt;
            pre_sync_r   <= pre_sync_nxt;
            syn_sync_r   <= syn_sync_nxt;
            lf_level_r   <= lf_level_nxt;
            pre_level_r  <= pre_level_nxt;
            syn_level_r  <= syn_level_nxt;
            irq_n_r      <= irq_n_nxt;
            pin_r        <= pin_nxt;
            xton_r       <= xton_nxt;
            rxon_r       <= rxon_nxt;
            sleep_r      <= sleep_nxt;
            gp0_r        <= gp0_nxt;
            hclk_r       <= hclk_nxt;
        end
    end

    always_comb
    begin
        reg_rdata                = rdata_r;
        interrupt_request_n      = irq_n_r;
        timer_expiry_pin         = pin_r;
        crystal_osc_enable       = xton_r;
        receiver_on              = rxon_r;
        sleep_state              = sleep_r;
        general_pin_zero_crystal = gp0_r;
        host_clock_lf_source     = hclk_r;
    end
endmodule : wakeup_timer

// file: verilog/wakeup_timer_pkg.sv
// constants for the wake-up timer and low-duty-cycle receive scheduler
package wakeup_timer_pkg;
    localparam logic [7:0] period_exponent_cfg_addr  = 8'h14;
    localparam logic [7:0] period_mantissa_high_addr = 8'h15;
    localparam logic [7:0] period_mantissa_low_addr  = 8'h16;
    localparam logic [7:0] count_high_addr           = 8'h17;
    localparam logic [7:0] count_low_addr            = 8'h18;
    localparam logic [7:0] receive_window_addr       = 8'h19;
    localparam logic [7:0] control_addr              = 8'h1A;
    localparam logic [7:0] status_addr               = 8'h1B;
    localparam logic [7:0] status_clear_addr         = 8'h1C;
    // field positions
    localparam int exponent_lsb     = 2;
    localparam int fine_divider_lsb = 0;
    localparam int ctl_timer_enable = 0;
    localparam int ctl_irq_enable   = 1;
    localparam int ctl_crystal_sel  = 2;
    localparam int ctl_ldc_enable   = 3;
    localparam int ctl_pin_route    = 4;
    localparam int ctl_sleep_cmd    = 5;
    // reset values
    localparam logic [7:0] period_exponent_cfg_rst = 8'h00;
    localparam logic [7:0] mantissa_rst            = 8'h00;
    localparam logic [7:0] receive_window_rst      = 8'h00;
    localparam logic [7:0] control_rst             = 8'h00;
    // each period tick is four low-frequency clock edges
    localparam logic [2:0] ticks_per_unit = 3'h4;
endpackage : wakeup_timer_pkg
